//--- src/wit_ctrl.sv
// Controller that drives the timer link from APB commands and records its events.
`timescale 1ns/10ps
module wit_ctrl (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST_B,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Link to the timer.
    wit_link_if.host LINK
);
    typedef struct packed {
        wit_pkg::wit_host_state_e state;
        logic req;
        logic write;
        logic target;
        logic [1:0] size;
        logic [15:0] wdata;
        logic settle;
        logic [7:0] rdata;
        logic [3:0] ev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } wit_host_s;

    wit_host_s s_q;
    wit_host_s s_d;
    logic acc;
    logic done;
    logic mapped;
    logic [3:0] ev_set;
    logic [3:0] ev_clr;

    always_comb begin
        s_d = s_q;
        s_d.settle = 1'b0;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        ev_clr = 4'h0;
        acc = PSEL & PENABLE;
        done = acc & s_q.pready;
        mapped = (PADDR == wit_pkg::CMD_OFF) | (PADDR == wit_pkg::STATUS_OFF)
            | (PADDR == wit_pkg::EVENT_OFF);
        // One wait state so that read data leaves a flip-flop.
        if (acc && !s_q.pready) begin
            s_d.pready = 1'b1;
            s_d.pslverr = ~mapped;
            s_d.prdata = 32'h0000_0000;
            if (!PWRITE && PADDR == wit_pkg::STATUS_OFF) begin
                s_d.prdata[wit_pkg::ST_BUSY_BIT] = (s_q.state == wit_pkg::H_WAIT);
                s_d.prdata[wit_pkg::ST_DATA_LSB +: 8] = s_q.rdata;
                s_d.prdata[wit_pkg::ST_EV_LSB +: 4] = s_q.ev;
            end else if (!PWRITE && PADDR == wit_pkg::EVENT_OFF) begin
                s_d.prdata[3:0] = s_q.ev;
            end
        end
        if (done && PWRITE && PADDR == wit_pkg::EVENT_OFF) begin
            ev_clr = PWDATA[3:0];
        end
        case (s_q.state)
            wit_pkg::H_IDLE: begin
                // Commands arriving while a transfer is in flight are dropped.
                if (done && PWRITE && PADDR == wit_pkg::CMD_OFF) begin
                    if (PWDATA[wit_pkg::CMD_SETTLE_BIT]) begin
                        s_d.settle = 1'b1;
                    end else begin
                        s_d.req = 1'b1;
                        s_d.write = ~PWDATA[wit_pkg::CMD_READ_BIT];
                        s_d.target = PWDATA[wit_pkg::CMD_TARGET_BIT];
                        s_d.size = PWDATA[wit_pkg::CMD_READ_BIT] ? wit_pkg::SIZE_BYTE
                            : wit_pkg::SIZE_WORD;
                        s_d.wdata[7:0] = PWDATA[wit_pkg::CMD_DATA_LSB +: 8];
                        if (PWDATA[wit_pkg::CMD_RAW_BIT]) begin
                            s_d.wdata[15:8] = PWDATA[wit_pkg::CMD_RAW_KEY_LSB +: 8];
                        end else if (PWDATA[wit_pkg::CMD_TARGET_BIT]) begin
                            s_d.wdata[15:8] = wit_pkg::CSR_KEY;
                        end else begin
                            s_d.wdata[15:8] = wit_pkg::COUNT_KEY;
                        end
                        s_d.state = wit_pkg::H_WAIT;
                    end
                end
            end
            wit_pkg::H_WAIT: begin
                if (LINK.ack) begin
                    s_d.req = 1'b0;
                    if (!s_q.write) begin
                        s_d.rdata = LINK.rdata;
                    end
                    s_d.state = wit_pkg::H_IDLE;
                end
            end
            default: begin
                s_d.req = 1'b0;
                s_d.state = wit_pkg::H_IDLE;
            end
        endcase
        ev_set = 4'h0;
        ev_set[wit_pkg::EV_RESET] = LINK.reset_req;
        ev_set[wit_pkg::EV_IRQ] = LINK.timer_irq;
        ev_set[wit_pkg::EV_RESUME] = LINK.clock_resume;
        ev_set[wit_pkg::EV_MANUAL] = LINK.reset_req & LINK.reset_manual;
        // A new event in the clearing cycle survives the clear.
        s_d.ev = (s_q.ev & ~ev_clr) | ev_set;
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            s_q <= '{state: wit_pkg::H_IDLE, size: wit_pkg::SIZE_BYTE, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign PRDATA = s_q.prdata;
    assign PREADY = s_q.pready;
    assign PSLVERR = s_q.pslverr;
    assign LINK.req = s_q.req;
    assign LINK.write = s_q.write;
    assign LINK.target = s_q.target;
    assign LINK.size = s_q.size;
    assign LINK.wdata = s_q.wdata;
    assign LINK.settle_start = s_q.settle;
endmodule

//--- src/wit_link_if.sv
// Connection between the watchdog interval timer and the party that drives it.
`timescale 1ns/10ps
interface wit_link_if;
    logic req;
    logic write;
    logic target;
    logic [1:0] size;
    logic [15:0] wdata;
    logic [7:0] rdata;
    logic ack;
    logic settle_start;
    logic reset_req;
    logic reset_manual;
    logic timer_irq;
    logic clock_resume;
    modport dev (
        input req, write, target, size, wdata, settle_start,
        output rdata, ack, reset_req, reset_manual, timer_irq, clock_resume
    );
    modport host (
        output req, write, target, size, wdata, settle_start,
        input rdata, ack, reset_req, reset_manual, timer_irq, clock_resume
    );
endinterface

//--- src/wit_pkg.sv
// Shared constants and types for the watchdog interval timer and its controller.
package wit_pkg;
    // Write keys carried in the upper byte of a word write.
    localparam logic [7:0] COUNT_KEY = 8'h5A;
    localparam logic [7:0] CSR_KEY = 8'hA5;
    // Values after power-on reset.
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [11:0] PRESCALE_RESET = 12'h000;
    // Control/status field positions.
    localparam int RUN_BIT = 7;
    localparam int MODE_BIT = 6;
    localparam int KIND_BIT = 5;
    localparam int GUARD_BIT = 4;
    localparam int PERIODIC_BIT = 3;
    localparam int CKS_LSB = 0;
    localparam int CKS_W = 3;
    localparam int PRESCALE_W = 12;
    // Prescaler shift per divider code: 1, 1/4, 1/16, 1/32, 1/64, 1/256, 1/1024, 1/4096.
    localparam logic [3:0] DIV_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'hA, 4'hC};
    // Access sizes and targets on the device bus.
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;
    localparam logic TARGET_COUNT = 1'b0;
    localparam logic TARGET_CSR = 1'b1;
    // Controller APB map.
    localparam int APB_AW = 12;
    localparam logic [11:0] CMD_OFF = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;
    localparam logic [11:0] EVENT_OFF = 12'h008;
    // Command word fields.
    localparam int CMD_DATA_LSB = 0;
    localparam int CMD_TARGET_BIT = 8;
    localparam int CMD_READ_BIT = 9;
    localparam int CMD_SETTLE_BIT = 10;
    localparam int CMD_RAW_BIT = 11;
    localparam int CMD_RAW_KEY_LSB = 16;
    // Status word fields.
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DATA_LSB = 8;
    // Event bits.
    localparam int EV_RESET = 0;
    localparam int EV_IRQ = 1;
    localparam int EV_RESUME = 2;
    localparam int EV_W = 3;
    localparam int EV_MANUAL = 3;
    localparam int ST_EV_LSB = 16;
    typedef enum logic [1:0] {
        H_IDLE = 2'b01,
        H_WAIT = 2'b10
    } wit_host_state_e;
endpackage

//--- src/wit_timer.sv
// Watchdog interval timer: counter, control/status register, prescaler and keyed bus.
`timescale 1ns/10ps
module wit_timer (
    // Clock and power-on reset.
    input wire logic CLK,
    input wire logic RST_B,
    // Link to the processor side.
    wit_link_if.dev LINK,
    // Observation of the count.
    output logic [7:0] COUNT_VALUE,
    output logic COUNT_ACTIVE
);
    typedef struct packed {
        logic [7:0] count;
        logic run;
        logic mode;
        logic kind;
        logic guard_flag;
        logic periodic_flag;
        logic [2:0] cks;
        logic [11:0] pre;
        logic settle;
        logic ack;
        logic [7:0] rdata;
        logic reset_req;
        logic reset_manual;
        logic irq;
        logic resume;
        logic counting;
    } wit_dev_s;

    wit_dev_s s_q;
    wit_dev_s s_d;

    // True on the prescaler cycle that ends one period of the selected division.
    function automatic logic div_tick(input logic [2:0] cks, input logic [11:0] pre);
        logic [11:0] mask;
        mask = ~(12'hFFF << wit_pkg::DIV_SHIFT[cks]);
        div_tick = ((pre & mask) == mask);
    endfunction

    // Packs the control fields into their byte positions.
    function automatic logic [7:0] csr_byte(input wit_dev_s s);
        logic [7:0] b;
        b = 8'h00;
        b[wit_pkg::RUN_BIT] = s.run;
        b[wit_pkg::MODE_BIT] = s.mode;
        b[wit_pkg::KIND_BIT] = s.kind;
        b[wit_pkg::GUARD_BIT] = s.guard_flag;
        b[wit_pkg::PERIODIC_BIT] = s.periodic_flag;
        b[wit_pkg::CKS_LSB +: wit_pkg::CKS_W] = s.cks;
        csr_byte = b;
    endfunction

    // Matches a word write aimed at one register that carries that register's key.
    // Anything else is still acknowledged, so a stray write stalls nothing but lands nowhere.
    function automatic logic keyed_write(input logic is_word, input logic in_target,
            input logic [7:0] in_key, input logic want_target, input logic [7:0] want_key);
        keyed_write = is_word & (in_target == want_target) & (in_key == want_key);
    endfunction

    logic tick;
    logic active;
    logic wrap;
    logic set_guard;
    logic set_periodic;
    logic take;
    logic word_write;
    logic [7:0] key;
    logic [7:0] low;
    logic count_write;
    logic csr_write;

    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.reset_req = 1'b0;
        s_d.irq = 1'b0;
        s_d.resume = 1'b0;
        set_guard = 1'b0;
        set_periodic = 1'b0;
        key = LINK.wdata[15:8];
        low = LINK.wdata[7:0];
        // The prescaler runs free so that a divider change never stalls the count.
        s_d.pre = s_q.pre + 12'h001;
        tick = div_tick(s_q.cks, s_q.pre);
        active = s_q.run | s_q.settle;
        wrap = active & tick & (s_q.count == 8'hFF);
        if (active & tick) begin
            s_d.count = s_q.count + 8'h01;
        end
        // The reset request, interrupt and resume flops pulse for the one cycle after the wrap edge, so one wrap
        // gives exactly one request.
        if (wrap) begin
            if (s_q.settle) begin
                // Settling takes priority; no flag moves and the control byte stays.
                s_d.settle = 1'b0;
                s_d.resume = 1'b1;
            end else if (s_q.mode) begin
                set_guard = 1'b1;
                s_d.reset_req = 1'b1;
                s_d.reset_manual = s_q.kind;
            end else begin
                set_periodic = 1'b1;
                s_d.irq = 1'b1;
            end
        end
        if (LINK.settle_start) begin
            s_d.settle = 1'b1;
        end
        // The acknowledge flop keeps a held request from being taken twice.
        take = LINK.req & ~s_q.ack;
        word_write = take & LINK.write & (LINK.size == wit_pkg::SIZE_WORD);
        count_write = keyed_write(word_write, LINK.target, key, wit_pkg::TARGET_COUNT,
            wit_pkg::COUNT_KEY);
        csr_write = keyed_write(word_write, LINK.target, key, wit_pkg::TARGET_CSR,
            wit_pkg::CSR_KEY);
        if (take) begin
            s_d.ack = 1'b1;
            if (!LINK.write) begin
                // Any read size returns the byte; software is expected to use byte reads.
                if (LINK.target == wit_pkg::TARGET_CSR) begin
                    s_d.rdata = csr_byte(s_q);
                end else begin
                    s_d.rdata = s_q.count;
                end
            end
        end
        if (count_write) begin
            // A keyed write overrides an increment in the same cycle.
            s_d.count = low;
        end
        s_d.guard_flag = s_q.guard_flag;
        s_d.periodic_flag = s_q.periodic_flag;
        if (csr_write) begin
            s_d.run = low[wit_pkg::RUN_BIT];
            s_d.mode = low[wit_pkg::MODE_BIT];
            s_d.kind = low[wit_pkg::KIND_BIT];
            s_d.cks = low[wit_pkg::CKS_LSB +: wit_pkg::CKS_W];
            s_d.guard_flag = s_q.guard_flag & low[wit_pkg::GUARD_BIT];
            s_d.periodic_flag = s_q.periodic_flag & low[wit_pkg::PERIODIC_BIT];
        end
        // A flag event in the clearing cycle still lands.
        s_d.guard_flag = s_d.guard_flag | set_guard;
        s_d.periodic_flag = s_d.periodic_flag | set_periodic;
        // The activity pin gets its own flop so that it never carries a gate's glitch.
        s_d.counting = s_d.run | s_d.settle;
    end

    // Only the power-on reset pin clears this state; the resets the block raises
    // go elsewhere in the chip and leave counter and control byte alone.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            s_q.count <= wit_pkg::COUNT_RESET;
            s_q.run <= wit_pkg::CSR_RESET[wit_pkg::RUN_BIT];
            s_q.mode <= wit_pkg::CSR_RESET[wit_pkg::MODE_BIT];
            s_q.kind <= wit_pkg::CSR_RESET[wit_pkg::KIND_BIT];
            s_q.guard_flag <= wit_pkg::CSR_RESET[wit_pkg::GUARD_BIT];
            s_q.periodic_flag <= wit_pkg::CSR_RESET[wit_pkg::PERIODIC_BIT];
            s_q.cks <= wit_pkg::CSR_RESET[wit_pkg::CKS_LSB +: wit_pkg::CKS_W];
            s_q.pre <= wit_pkg::PRESCALE_RESET;
            s_q.settle <= 1'b0;
            s_q.ack <= 1'b0;
            s_q.rdata <= 8'h00;
            s_q.reset_req <= 1'b0;
            s_q.reset_manual <= 1'b0;
            s_q.irq <= 1'b0;
            s_q.resume <= 1'b0;
            s_q.counting <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // A mode or divider change while counting is not guarded: the prescaler is never
    // cleared, so the first tick after a divider change may come early.
    // After a settle wrap the counter stops unless the run bit is set.
    assign LINK.rdata = s_q.rdata;
    assign LINK.ack = s_q.ack;
    assign LINK.reset_req = s_q.reset_req;
    assign LINK.reset_manual = s_q.reset_manual;
    assign LINK.timer_irq = s_q.irq;
    assign LINK.clock_resume = s_q.resume;
    assign COUNT_VALUE = s_q.count;
    assign COUNT_ACTIVE = s_q.counting;
endmodule

//--- tb/watchdog_interval_timer_test.sv
// Bench that drives the controller over APB and checks the timer through it.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module watchdog_interval_timer_test;
    logic clk;
    logic rst_b;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] count_value;
    logic count_active;
    logic [31:0] rd;
    logic err;
    logic [7:0] v;
    int errors;
    int tests_run;
    int n;
    int k;
    int divs [8] = '{1, 4, 16, 32, 64, 256, 1024, 4096};
    wit_link_if wit_link_if_inst ();
    wit_timer wit_timer_inst (.CLK(clk), .RST_B(rst_b), .LINK(wit_link_if_inst),
        .COUNT_VALUE(count_value), .COUNT_ACTIVE(count_active));
    wit_ctrl wit_ctrl_inst (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .LINK(wit_link_if_inst));
    wit_link_asserts wit_link_asserts_inst (.CLK(clk), .RST_B(rst_b),
        .req(wit_link_if_inst.req), .ack(wit_link_if_inst.ack),
        .reset_req(wit_link_if_inst.reset_req), .timer_irq(wit_link_if_inst.timer_irq),
        .clock_resume(wit_link_if_inst.clock_resume), .COUNT_VALUE(count_value));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task results;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // The slave's latency is not assumed; PREADY ends a wait, and the bound only ends a hung one.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            errors++;
            results;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Issue one link command and wait until the controller is idle again.
    task op(input logic [7:0] key, input logic [3:0] f, input logic [7:0] d);
        int i;
        apb(1'b1, wit_pkg::CMD_OFF, {8'h00, key, 4'h0, f, d});
        for (i = 0; i < 20; i++) begin
            apb(1'b0, wit_pkg::STATUS_OFF, 32'h0000_0000);
            if (rd[0] === 1'b0) break;
        end
        if (i == 20) begin
            errors++;
            results;
        end
    endtask
    task wrv(input logic t, input logic [7:0] d);
        op(8'h00, {3'b000, t}, d);
    endtask
    task rchk(input logic t, input logic [7:0] e);
        op(8'h00, {3'b001, t}, 8'h00);
        `CHK(t ? "control" : "count", e, rd[15:8])
    endtask
    task evwait(input int b);
        int i;
        for (i = 0; i < 700; i++) begin
            apb(1'b0, wit_pkg::EVENT_OFF, 32'h0000_0000);
            if (rd[b] === 1'b1) break;
        end
        if (i == 700) begin
            errors++;
            results;
        end
    endtask
    task waitchg;
        logic [7:0] c;
        c = count_value;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (count_value === c && n < 5000);
        if (count_value === c) begin
            errors++;
            results;
        end
    endtask
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        errors = 0;
        tests_run = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rchk(1'b0, 8'h00);
        rchk(1'b1, 8'h00);
        wrv(1'b0, 8'h37);
        rchk(1'b0, 8'h37);
        op(8'hA5, 4'b1000, 8'h99);
        rchk(1'b0, 8'h37);
        op(8'h5A, 4'b1001, 8'h80);
        rchk(1'b1, 8'h00);
        v = count_value;
        repeat (40) @(posedge clk);
        `CHK("held count", v, count_value)
        apb(1'b0, 12'h00C, 32'h0000_0000);
        `CHK("unmapped error", 1'b1, err)
        $display("access test done");
        wrv(1'b0, 8'hFE);
        wrv(1'b1, 8'h80);
        evwait(1);
        rchk(1'b1, 8'h88);
        apb(1'b0, wit_pkg::EVENT_OFF, 32'h0000_0000);
        `CHK("events", 4'h2, rd[3:0])
        wrv(1'b1, 8'h08);
        rchk(1'b1, 8'h08);
        wrv(1'b1, 8'h00);
        rchk(1'b1, 8'h00);
        apb(1'b1, wit_pkg::EVENT_OFF, 32'h0000_000F);
        $display("interval test done");
        for (k = 0; k < 2; k++) begin
            wrv(1'b1, {2'b01, k[0], 5'h00});
            wrv(1'b0, 8'hFE);
            wrv(1'b1, {2'b11, k[0], 5'h00});
            evwait(0);
            apb(1'b0, wit_pkg::EVENT_OFF, 32'h0000_0000);
            `CHK("manual kind", k[0], rd[3])
            rchk(1'b1, {2'b11, k[0], 5'h10});
            wrv(1'b1, 8'h00);
            apb(1'b1, wit_pkg::EVENT_OFF, 32'h0000_000F);
        end
        $display("watchdog test done");
        wrv(1'b1, 8'h41);
        wrv(1'b0, 8'hFE);
        op(8'h00, 4'b0100, 8'h00);
        evwait(2);
        apb(1'b0, wit_pkg::EVENT_OFF, 32'h0000_0000);
        `CHK("events", 4'h4, rd[3:0])
        rchk(1'b1, 8'h41);
        rchk(1'b0, 8'h00);
        $display("settle test done");
        // The first change after a divider switch may be a partial period.
        for (k = 0; k < 8; k++) begin
            wrv(1'b1, 8'h80 | k[7:0]);
            `CHK("active", 1'b1, count_active)
            waitchg;
            waitchg;
            `CHK("tick period", divs[k], n)
        end
        wrv(1'b1, 8'h00);
        `CHK("active", 1'b0, count_active)
        $display("divider test done");
        results;
    end
endmodule

//--- tb/wit_link_asserts.sv
// Assertions on the link between the timer and its controller.
`timescale 1ns/10ps
module wit_link_asserts (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST_B,
    // Link handshake and events.
    input wire logic req,
    input wire logic ack,
    input wire logic reset_req,
    input wire logic timer_irq,
    input wire logic clock_resume,
    // Observed count.
    input wire logic [7:0] COUNT_VALUE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    ack_after_req_a: assert property (req && !ack |=> ack)
        else $error("No acknowledge one cycle after a request.");
    ack_single_a: assert property (ack |=> !ack)
        else $error("Acknowledge lasted more than one cycle.");
    req_hold_a: assert property (req && !ack |=> req)
        else $error("Request dropped before its acknowledge.");
    irq_on_wrap_a: assert property (timer_irq |-> COUNT_VALUE == 8'h00
        && $past(COUNT_VALUE) == 8'hFF) else $error("Interrupt without a wrap.");
    rst_on_wrap_a: assert property (reset_req |-> COUNT_VALUE == 8'h00
        && $past(COUNT_VALUE) == 8'hFF) else $error("Reset request without a wrap.");
    resume_on_wrap_a: assert property (clock_resume |-> COUNT_VALUE == 8'h00
        && $past(COUNT_VALUE) == 8'hFF) else $error("Clock resume without a wrap.");
    irq_single_a: assert property (timer_irq |=> !timer_irq)
        else $error("Interrupt pulse longer than one cycle.");
    one_event_a: assert property ($onehot0({reset_req, timer_irq, clock_resume}))
        else $error("Two overflow events at once.");
    count_step_a: assert property ($changed(COUNT_VALUE) && !ack && !$past(ack)
        |-> COUNT_VALUE == $past(COUNT_VALUE) + 8'h01) else $error("Count did not step by one.");
    cover property (timer_irq);
    cover property (reset_req);
    cover property (clock_resume);
    cover property (req ##1 ack);
endmodule
